// File: hdl/alu_cfg.svh
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// ---------------------------------------------------------------------------
// word and register file shape
// ---------------------------------------------------------------------------
`define ALU_WORD_W   8
`define ALU_NREG     16
`define ALU_IDX_W    4
`define ALU_AC_IDX   4'hF
`define ALU_T_IDX    4'hE
`define ALU_ZERO     8'h00
`define ALU_ONES     8'hFF

// ---------------------------------------------------------------------------
// function group codes
// ---------------------------------------------------------------------------
`define ALU_FG_DEC   3'h2
`define ALU_FG_AND   3'h5
`define ALU_FG_OR    3'h6
`define ALU_FG_XNOR  3'h7

`endif

// File: hdl/alu_pkg.sv
`include "alu_cfg.svh"

package alu_pkg;

  // register group selection
  typedef enum logic [1:0] {
    ALU_RG_NONE = 2'b00,
    ALU_RG_SCR  = 2'b01,
    ALU_RG_MEM  = 2'b10,
    ALU_RG_INP  = 2'b11
  } alu_rgrp_t;

  // one micro-operation from the control unit
  typedef struct packed {
    logic [2:0]              fgrp;
    alu_rgrp_t               rgrp;
    logic [`ALU_IDX_W-1:0]   rn;
    logic                    at_sel;
  } alu_req_t;

  // data buses
  typedef struct packed {
    logic [`ALU_WORD_W-1:0]  k;
    logic [`ALU_WORD_W-1:0]  m;
    logic [`ALU_WORD_W-1:0]  i;
  } alu_bus_t;

endpackage : alu_pkg

// File: hdl/alu_slice.sv
`timescale 1ns/100ps
// What this block does
// - group 5 memory: mask AND into register
// - zero mask clears target, carry passes
// - all-ones mask loads memory bus, tests nonzero
// - group 6 scratch: OR masked working register
// - group 6 scratch zero mask is null operation
// - all-ones mask ORs working register in
// - group 6 memory: bus OR masked working
// - zero mask loads memory bus plain
// - all-ones mask ORs memory with working
// - group 6 input: OR masked input bus
// - all-ones mask ORs input, tests input
// - group 7 scratch: XNOR masked working
// - zero mask inverts scratch register
// - all-ones XNOR, carry on their AND
// - group 7 memory: XNOR masked working
// - zero mask loads inverted memory bus
// - all-ones XNOR memory, carry on AND
// - group 7 input: XNOR masked input
// - zero mask inverts AC or T target
// - all-ones XNOR input, carry on AND
// - two's complement; minus one adds ones
// - scratch selection also reaches T, AC

module alu_slice (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire alu_pkg::alu_req_t      req,
  input  wire alu_pkg::alu_bus_t      bus,
  input  wire logic                   carry_input,
  output logic                        carry_output,
  output logic [`ALU_WORD_W-1:0]      main_working_register,
  output logic [`ALU_WORD_W-1:0]      result_ff_out
);
  import alu_pkg::*;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [`ALU_WORD_W-1:0] reg_ff [`ALU_NREG];
  logic                   carry_ff;
  logic [`ALU_WORD_W-1:0] result_ff;
  logic [`ALU_IDX_W-1:0]  last_tgt_ff;

  // two's complement add with carry in, carry out on top bit
  function automatic logic [`ALU_WORD_W:0] add_tc(
    input logic [`ALU_WORD_W-1:0] a,
    input logic [`ALU_WORD_W-1:0] b,
    input logic                   c
  );
    add_tc = {1'b0, a} + {1'b0, b} + {{`ALU_WORD_W{1'b0}}, c};
  endfunction : add_tc

  // -------------------------------------------------------------------------
  // operand selection
  // -------------------------------------------------------------------------
  wire                    is_scr   = (req.rgrp == ALU_RG_SCR);
  wire                    is_mem   = (req.rgrp == ALU_RG_MEM);
  wire                    is_inp   = (req.rgrp == ALU_RG_INP);
  wire [`ALU_IDX_W-1:0]   at_idx   = req.at_sel ? `ALU_T_IDX : `ALU_AC_IDX;
  // scratch index spans general registers plus T and AC
  wire [`ALU_IDX_W-1:0]   tgt_idx  = is_scr ? req.rn : at_idx;
  wire [`ALU_WORD_W-1:0]  ac_val   = reg_ff[`ALU_AC_IDX];
  wire [`ALU_WORD_W-1:0]  tgt_val  = reg_ff[tgt_idx];
  // first operand: register, memory bus, or AC/T
  wire [`ALU_WORD_W-1:0]  opa      = is_mem ? bus.m : tgt_val;
  // masked second operand: input under input selection, else AC
  wire [`ALU_WORD_W-1:0]  opb      = is_inp ? (bus.i & bus.k)
                                            : (ac_val & bus.k);

  // -------------------------------------------------------------------------
  // per-group results and carry
  // -------------------------------------------------------------------------
  wire [`ALU_WORD_W-1:0]  and_res  = opa & bus.k;
  wire [`ALU_WORD_W-1:0]  or_res   = opa | opb;
  wire [`ALU_WORD_W-1:0]  xnor_res = ~(opa ^ opb);
  wire [`ALU_WORD_W:0]    dec_sum  = add_tc(opb, `ALU_ONES,
                                            carry_input);
  wire                    and_co   = carry_input | (|and_res);
  wire                    or_co    = carry_input | (|opb);
  // register or bus AND masked operand, ORed wordwise into the carry
  wire                    xnor_co  = carry_input | (|(opa & opb));

  wire                    valid    = (req.rgrp != ALU_RG_NONE);
  wire                    g_and    = valid & (req.fgrp == `ALU_FG_AND);
  wire                    g_or     = valid & (req.fgrp == `ALU_FG_OR);
  wire                    g_xnor   = valid & (req.fgrp == `ALU_FG_XNOR);
  wire                    g_dec    = valid & (req.fgrp == `ALU_FG_DEC);
  wire                    do_write = g_and | g_or | g_xnor | g_dec;

  wire [`ALU_WORD_W-1:0]  nxt_res  = g_and  ? and_res  :
                                     g_or   ? or_res   :
                                     g_xnor ? xnor_res :
                                     dec_sum[`ALU_WORD_W-1:0];
  // other groups pass carry straight through
  wire                    nxt_co   = g_and  ? and_co  :
                                     g_or   ? or_co   :
                                     g_xnor ? xnor_co :
                                     g_dec  ? dec_sum[`ALU_WORD_W] :
                                     carry_input;

  // -------------------------------------------------------------------------
  // register file and carry flop
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int j = 0; j < `ALU_NREG; j++) begin
        reg_ff[j] <= `ALU_ZERO;
      end
    end else if (clk_en && do_write) begin
      reg_ff[tgt_idx] <= nxt_res;
    end
  end

  // carry, result copy and last target
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      carry_ff    <= 1'b0;
      result_ff   <= `ALU_ZERO;
      last_tgt_ff <= `ALU_AC_IDX;
    end else if (clk_en) begin
      carry_ff    <= nxt_co;
      result_ff   <= do_write ? nxt_res : tgt_val;
      last_tgt_ff <= tgt_idx;
    end
  end

  assign carry_output          = carry_ff;
  assign main_working_register = reg_ff[`ALU_AC_IDX];
  assign result_ff_out         = result_ff;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_and_mem_load: assert property (
    clk_en && g_and && is_mem |=>
      reg_ff[last_tgt_ff] == ($past(bus.m) & $past(bus.k)) &&
      carry_output == ($past(carry_input) |
                       (|($past(bus.m) & $past(bus.k)))))
    else $error("and group memory result wrong");

  a_and_clear: assert property (
    clk_en && g_and && !is_scr && bus.k == `ALU_ZERO |=>
      reg_ff[last_tgt_ff] == `ALU_ZERO &&
      carry_output == $past(carry_input))
    else $error("clear did not zero target");

  a_and_test: assert property (
    clk_en && g_and && is_inp && bus.k == `ALU_ONES |=>
      reg_ff[last_tgt_ff] == $past(tgt_val) &&
      carry_output == ($past(carry_input) | (|$past(tgt_val))))
    else $error("test zero changed register or carry");

  a_or_scratch: assert property (
    clk_en && g_or && is_scr && req.rn != `ALU_AC_IDX |=>
      reg_ff[last_tgt_ff] == ($past(tgt_val) | $past(opb)) &&
      carry_output == ($past(carry_input) | (|$past(opb))))
    else $error("or into scratch wrong");

  a_or_null: assert property (
    clk_en && g_or && !is_mem && bus.k == `ALU_ZERO |=>
      reg_ff[last_tgt_ff] == $past(tgt_val) &&
      carry_output == $past(carry_input))
    else $error("null operation changed state");

  a_or_mem_plain: assert property (
    clk_en && g_or && is_mem && bus.k == `ALU_ZERO |=>
      reg_ff[last_tgt_ff] == $past(bus.m) &&
      carry_output == $past(carry_input))
    else $error("plain memory load wrong");

  a_or_input: assert property (
    clk_en && g_or && is_inp && bus.k == `ALU_ONES |=>
      carry_output == ($past(carry_input) | (|$past(bus.i))))
    else $error("or input carry wrong");

  a_xnor_invert: assert property (
    clk_en && g_xnor && !is_mem && bus.k == `ALU_ZERO |=>
      reg_ff[last_tgt_ff] == ~$past(tgt_val) &&
      carry_output == $past(carry_input))
    else $error("invert did not complement");

  a_xnor_mem: assert property (
    clk_en && g_xnor && is_mem && bus.k == `ALU_ONES |=>
      reg_ff[last_tgt_ff] == ~($past(bus.m) ^ $past(ac_val)) &&
      carry_output == ($past(carry_input) |
                       (|($past(bus.m) & $past(ac_val)))))
    else $error("xnor memory wrong");

  a_freeze_hold: assert property (
    !clk_en |=> $stable(carry_output) && $stable(main_working_register))
    else $error("state moved while clock enable low");

endmodule : alu_slice

// File: verif/alu_ctl_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// control unit model: drives one micro-operation per clock
// ---------------------------------------------------------------------------
module alu_ctl_model
  import alu_pkg::*;
(
  output alu_pkg::alu_req_t req,
  output alu_pkg::alu_bus_t bus,
  output logic              carry_input,
  output logic              clk_en
);
  // known values from time zero, before the first operation
  initial begin
    req         = '0;
    bus         = '0;
    carry_input = 1'b0;
    clk_en      = 1'b0;
  end

  // caller invokes this just after a rising edge; fields held a full cycle
  task automatic drive(input alu_req_t r, input alu_bus_t b,
                       input logic ci, input logic en);
    req         = r;
    bus         = b;
    carry_input = ci;
    clk_en      = en;
  endtask : drive
endmodule : alu_ctl_model

// File: verif/test_alu_slice_logic_functions.sv
`timescale 1ns/100ps
`include "alu_cfg.svh"
module test_alu_slice_logic_functions;
  import alu_pkg::*;
  logic                   clk, resetn, clk_en, carry_input, carry_output;
  alu_req_t               req;
  alu_bus_t               bus;
  logic [`ALU_WORD_W-1:0] acc_o, res_o, exp_res;
  logic [`ALU_WORD_W-1:0] regs [`ALU_NREG];
  logic                   exp_co;
  int                     failures, num_checks, cycles;

  alu_ctl_model mcu_u (.req(req), .bus(bus), .carry_input(carry_input),
                       .clk_en(clk_en));
  alu_slice dut_u (.clk(clk), .resetn(resetn), .clk_en(clk_en), .req(req),
    .bus(bus), .carry_input(carry_input), .carry_output(carry_output),
    .main_working_register(acc_o), .result_ff_out(res_o));

  // expected {write, carry, value} from the function tables
  function automatic logic [9:0] calc(alu_req_t r, alu_bus_t b, logic ci,
                                      logic [7:0] tv, logic [7:0] ac);
    logic [7:0] a, m2;
    logic [8:0] s;
    a  = (r.rgrp == ALU_RG_MEM) ? b.m : tv;
    m2 = (r.rgrp == ALU_RG_INP) ? (b.i & b.k) : (ac & b.k);
    s  = {1'b0, m2} + 9'h0FF + {8'h00, ci};
    if (r.rgrp == ALU_RG_NONE) return {1'b0, ci, tv};
    case (r.fgrp)
      `ALU_FG_AND:  return {1'b1, ci | (|(a & b.k)), a & b.k};
      `ALU_FG_OR:   return {1'b1, ci | (|m2), a | m2};
      `ALU_FG_XNOR: return {1'b1, ci | (|(a & m2)), ~(a ^ m2)};
      `ALU_FG_DEC:  return {1'b1, s};
      default: return {1'b0, ci, tv};
    endcase
  endfunction : calc

  task automatic check(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask : check

  // check the previous operation, then present the next one
  task automatic step(input alu_req_t r, input alu_bus_t b, input logic ci,
                      input logic en);
    logic [9:0] e;
    logic [3:0] t;
    @(posedge clk);
    #1;
    check("acc", acc_o, regs[`ALU_AC_IDX]);
    check("carry", {7'h00, carry_output}, {7'h00, exp_co});
    check("result", res_o, exp_res);
    mcu_u.drive(r, b, ci, en);
    t = (r.rgrp == ALU_RG_SCR) ? r.rn
      : (r.at_sel ? `ALU_T_IDX : `ALU_AC_IDX);
    e = calc(r, b, ci, regs[t], regs[`ALU_AC_IDX]);
    if (en) begin
      if (e[9]) regs[t] = e[7:0];
      exp_co  = e[8];
      exp_res = e[7:0];
    end
  endtask : step

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      test_done();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    alu_req_t   r;
    alu_bus_t   b;
    logic [7:0] kt [3];
    resetn  = 1'b0;
    exp_co  = 1'b0;
    exp_res = 8'h00;
    foreach (regs[n]) regs[n] = 8'h00;
    void'($urandom(32'h97E10C88));
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    for (int n = 0; n < 440; n++) begin
      r.fgrp   = (n < 36) ? 3'(n / 9 + 5) : 3'($urandom_range(0, 7));
      if (n < 36 && r.fgrp == 3'h0) r.fgrp = 3'h2;
      r.rgrp   = alu_rgrp_t'(2'($urandom_range((n < 36) ? 1 : 0, 3)));
      r.rn     = 4'($urandom);
      r.at_sel = 1'($urandom);
      b.m      = 8'($urandom);
      b.i      = 8'($urandom);
      kt       = '{8'h00, 8'hFF, 8'($urandom)};
      b.k      = kt[n % 3];
      step(r, b, 1'($urandom), (n < 36) || ($urandom_range(0, 7) != 0));
      if (n == 35) $display("corner masks done");
    end
    $display("random operations done");
    step(r, b, 1'b0, 1'b0);
    test_done();
  end
endmodule : test_alu_slice_logic_functions
